// ===== design/pcr_regs.vh
// offsets, field positions, reset values and timing for the phy register pair
`ifndef PCR_REGS_VH
`define PCR_REGS_VH

// register offsets from the control/status register base
`define PCR_CTRL_OFS   8'hb4
`define PCR_STAT_OFS   8'hb8

// control word field positions
`define PCR_C_RST      15
`define PCR_C_LPBK     14
`define PCR_C_SPD      13
`define PCR_C_AUTONEG_ENABLE     12
`define PCR_C_PD       11
`define PCR_C_AUTONEG_RESTART     9
`define PCR_C_DPX      8
`define PCR_C_COLT     7

// status word field positions
`define PCR_S_ANC      5
`define PCR_S_RF       4
`define PCR_S_LINK     2
`define PCR_S_JAB      1

// control word reset value: speed 100 and negotiation enabled
`define PCR_CTRL_RST   16'h3000
// status fixed ability bits: 14..11, 3 and extended-register bit 0
`define PCR_STAT_FIXED 16'h7809

// timing
`define PCR_CLK_NS     100
`define PCR_PHY_SOFT_RESET_NS    2000
`define PCR_AUTONEG_RESTART_NS    100
`define PCR_PHY_SOFT_RESET_CYC   ((`PCR_PHY_SOFT_RESET_NS + `PCR_CLK_NS - 1) / `PCR_CLK_NS)
`define PCR_AUTONEG_RESTART_CYC   ((`PCR_AUTONEG_RESTART_NS + `PCR_CLK_NS - 1) / `PCR_CLK_NS)

`endif

// ===== design/pcr_sync.v
// two-flop synchroniser for a bundle of pin-level inputs
module pcr_sync #(
  parameter W = 1
) (
  // clock and reset
  input  wire         clk,
  input  wire         arst_n,
  // asynchronous levels in, synchronised levels out
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // first stage feeds only the second stage
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;

endmodule // pcr_sync

// ===== design/pcr_seq.v
// retriggerable fixed-length timer: active for CYCLES cycles, then done pulse
module pcr_seq #(
  parameter CYCLES = 1
) (
  // clock and reset
  input  wire clk,
  input  wire arst_n,
  // start pulse, busy level, end pulse
  input  wire start,
  output wire active,
  output wire done
);

  localparam [31:0] LOAD = CYCLES - 1;

  reg [15:0] cnt_q;
  reg        active_q;
  reg        done_q;

  // a fresh start while busy reloads the count instead of being lost
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q    <= 16'h0000;
      active_q <= 1'b0;
      done_q   <= 1'b0;
    end else if (start) begin
      cnt_q    <= LOAD[15:0];
      active_q <= 1'b1;
      done_q   <= 1'b0;
    end else if (active_q) begin
      if (cnt_q == 16'h0000) begin
        active_q <= 1'b0;
        done_q   <= 1'b1;
      end else begin
        cnt_q    <= cnt_q - 16'h0001;
        done_q   <= 1'b0;
      end
    end else begin
      done_q <= 1'b0;
    end
  end

  assign active = active_q;
  assign done   = done_q;

endmodule // pcr_seq

// ===== design/pcr_top.v
// transceiver control and status word pair with phy control outputs
`include "pcr_regs.vh"

module pcr_top (
  // clock and reset
  input  wire        clk,
  input  wire        arst_n,
  // register access, double words only
  input  wire [7:0]  reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [31:0] reg_wdata,
  output wire [31:0] reg_rdata,
  output wire        reg_ack,
  // transceiver status pins, asynchronous
  input  wire        phy_link_up,
  input  wire        phy_remote_fault,
  input  wire        phy_jabber,
  input  wire        phy_an_done,
  input  wire        phy_an_speed_100,
  input  wire        phy_an_full_duplex,
  // transceiver controls
  output wire        phy_reset_out,
  output wire        phy_loopback_select,
  output wire        phy_speed_100,
  output wire        phy_full_duplex,
  output wire        phy_an_enable,
  output wire        phy_an_restart,
  output wire        phy_power_down,
  output wire        phy_collision_test
);

  // transceiver operating states
  localparam [4:0] ST_RST   = 5'h01;
  localparam [4:0] ST_OFF   = 5'h02;
  localparam [4:0] ST_NEG   = 5'h04;
  localparam [4:0] ST_FIX   = 5'h08;
  localparam [4:0] ST_UP    = 5'h10;

  // ---------------------------------------------------------------
  // pin synchronisation
  wire [5:0] pins_s;
  wire       link_s;
  wire       rfault_s;
  wire       jab_s;
  wire       an_done_s;
  wire       an_spd_s;
  wire       an_dpx_s;

  pcr_sync #(
    .W (6)
  ) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .d      ({phy_an_full_duplex, phy_an_speed_100, phy_an_done,
              phy_jabber, phy_remote_fault, phy_link_up}),
    .q      (pins_s)
  );

  assign link_s    = pins_s[0];
  assign rfault_s  = pins_s[1];
  assign jab_s     = pins_s[2];
  assign an_done_s = pins_s[3];
  assign an_spd_s  = pins_s[4];
  assign an_dpx_s  = pins_s[5];

  // ---------------------------------------------------------------
  // address decode; only the low 16 bits of a write carry data
  wire ctrl_hit;
  wire stat_hit;
  wire ctrl_wr;
  wire stat_rd;

  assign ctrl_hit = (reg_addr == `PCR_CTRL_OFS);
  assign stat_hit = (reg_addr == `PCR_STAT_OFS);
  assign ctrl_wr  = reg_wr & ctrl_hit;
  assign stat_rd  = reg_rd & stat_hit;

  // ---------------------------------------------------------------
  // control word fields
  reg ctl_rst_q;
  reg ctl_lpbk_q;
  reg ctl_spd_q;
  reg ctl_autoneg_enable_q;
  reg ctl_pd_q;
  reg ctl_autoneg_restart_q;
  reg ctl_dpx_q;
  reg ctl_colt_q;

  wire rst_start;
  wire rst_active;
  wire rst_done;
  wire autoneg_restart_start;
  wire autoneg_restart_active;
  wire autoneg_restart_done;

  assign rst_start  = ctrl_wr & reg_wdata[`PCR_C_RST];
  assign autoneg_restart_start = ctrl_wr & reg_wdata[`PCR_C_AUTONEG_RESTART];

  // soft reset hold time
  pcr_seq #(
    .CYCLES (`PCR_PHY_SOFT_RESET_CYC)
  ) u_rst_seq (
    .clk    (clk),
    .arst_n (arst_n),
    .start  (rst_start),
    .active (rst_active),
    .done   (rst_done)
  );

  // negotiation restart pulse length
  pcr_seq #(
    .CYCLES (`PCR_AUTONEG_RESTART_CYC)
  ) u_autoneg_restart_seq (
    .clk    (clk),
    .arst_n (arst_n),
    .start  (autoneg_restart_start),
    .active (autoneg_restart_active),
    .done   (autoneg_restart_done)
  );

  // plain read/write fields; reserved bits are simply not stored
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_lpbk_q <= 1'b0;
      ctl_spd_q  <= 1'b1;
      ctl_autoneg_enable_q <= 1'b1;
      ctl_pd_q   <= 1'b0;
      ctl_dpx_q  <= 1'b0;
      ctl_colt_q <= 1'b0;
    end else if (ctrl_wr) begin
      ctl_lpbk_q <= reg_wdata[`PCR_C_LPBK];
      ctl_spd_q  <= reg_wdata[`PCR_C_SPD];
      ctl_autoneg_enable_q <= reg_wdata[`PCR_C_AUTONEG_ENABLE];
      ctl_pd_q   <= reg_wdata[`PCR_C_PD];
      ctl_dpx_q  <= reg_wdata[`PCR_C_DPX];
      ctl_colt_q <= reg_wdata[`PCR_C_COLT];
    end
  end

  // self-clearing bits; a new write of one beats the clearing done
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_rst_q  <= 1'b0;
      ctl_autoneg_restart_q <= 1'b0;
    end else begin
      if (rst_start) begin
        ctl_rst_q <= 1'b1;
      end else if (rst_done) begin
        ctl_rst_q <= 1'b0;
      end
      if (autoneg_restart_start) begin
        ctl_autoneg_restart_q <= 1'b1;
      end else if (autoneg_restart_done) begin
        ctl_autoneg_restart_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // speed and duplex in force: negotiated result or forced bits
  wire spd_eff;
  wire dpx_eff;

  assign spd_eff = ctl_autoneg_enable_q ? an_spd_s : ctl_spd_q;
  assign dpx_eff = ctl_autoneg_enable_q ? an_dpx_s : ctl_dpx_q;

  // ---------------------------------------------------------------
  // transceiver state; soft reset outranks power-down
  reg [4:0] state_q;
  reg [4:0] state_d;

  always @* begin
    state_d = state_q;
    if (rst_active) begin
      state_d = ST_RST;
    end else if (ctl_pd_q) begin
      state_d = ST_OFF;
    end else begin
      case (state_q)
        ST_RST, ST_OFF: begin
          state_d = ctl_autoneg_enable_q ? ST_NEG : ST_FIX;
        end
        ST_NEG: begin
          if (!ctl_autoneg_enable_q) begin
            state_d = ST_FIX;
          end else if (!autoneg_restart_active && an_done_s) begin
            state_d = ST_UP;
          end
        end
        ST_UP: begin
          if (!ctl_autoneg_enable_q) begin
            state_d = ST_FIX;
          end else if (autoneg_restart_active || !an_done_s) begin
            state_d = ST_NEG;
          end
        end
        ST_FIX: begin
          if (ctl_autoneg_enable_q) begin
            state_d = ST_NEG;
          end
        end
        default: begin
          state_d = ST_RST;
        end
      endcase
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_RST;
    end else begin
      state_q <= state_d;
    end
  end

  // ---------------------------------------------------------------
  // registered transceiver controls
  reg phy_rst_q;
  reg phy_lpbk_q;
  reg phy_spd_q;
  reg phy_dpx_q;
  reg phy_autoneg_enable_q;
  reg phy_autoneg_restart_q;
  reg phy_pd_q;
  reg phy_colt_q;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phy_rst_q  <= 1'b1;
      phy_lpbk_q <= 1'b0;
      phy_spd_q  <= 1'b1;
      phy_dpx_q  <= 1'b0;
      phy_autoneg_enable_q <= 1'b1;
      phy_autoneg_restart_q <= 1'b0;
      phy_pd_q   <= 1'b0;
      phy_colt_q <= 1'b0;
    end else begin
      phy_rst_q  <= (state_d == ST_RST);
      phy_lpbk_q <= ctl_lpbk_q;
      phy_spd_q  <= spd_eff;
      phy_dpx_q  <= dpx_eff;
      phy_autoneg_enable_q <= ctl_autoneg_enable_q;
      phy_autoneg_restart_q <= autoneg_restart_active & ctl_autoneg_enable_q;
      phy_pd_q   <= (state_d == ST_OFF);
      phy_colt_q <= ctl_colt_q;
    end
  end

  // ---------------------------------------------------------------
  // latched status; a pin event in the read cycle beats the clear
  reg  rf_q;
  reg  link_q;
  reg  jab_q;
  wire link_ok;

  // link counts as failed while the transceiver is held or off
  assign link_ok = link_s & (state_q != ST_RST) & (state_q != ST_OFF);

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rf_q   <= 1'b0;
      link_q <= 1'b0;
      jab_q  <= 1'b0;
    end else begin
      if (rfault_s) begin
        rf_q <= 1'b1;
      end else if (stat_rd) begin
        rf_q <= 1'b0;
      end
      if (!link_ok) begin
        link_q <= 1'b0;
      end else if (stat_rd) begin
        link_q <= 1'b1;
      end
      if (jab_s && !spd_eff) begin
        jab_q <= 1'b1;
      end else if (stat_rd) begin
        jab_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // read views; reserved bits are constant zero
  wire [15:0] ctrl_view;
  wire [15:0] stat_view;
  reg  [15:0] rd_word;

  assign ctrl_view = {ctl_rst_q, ctl_lpbk_q, ctl_spd_q, ctl_autoneg_enable_q,
                      ctl_pd_q, 1'b0, ctl_autoneg_restart_q, ctl_dpx_q,
                      ctl_colt_q, 7'h00};

  // fixed abilities ored with live bits; writes never reach here
  assign stat_view = `PCR_STAT_FIXED
                   | {10'h000, (state_q == ST_UP), rf_q,
                      1'b0, link_q, jab_q, 1'b0};

  always @* begin
    rd_word = 16'h0000;
    if (ctrl_hit) begin
      rd_word = ctrl_view;
    end else if (stat_hit) begin
      rd_word = stat_view;
    end
  end

  // answer one cycle after the strobe; unmapped reads return zero
  reg [31:0] rdata_q;
  reg        ack_q;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 32'h00000000;
      ack_q   <= 1'b0;
    end else begin
      ack_q <= reg_rd | reg_wr;
      if (reg_rd) begin
        rdata_q <= {16'h0000, rd_word};
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs, all from flops
  assign reg_rdata           = rdata_q;
  assign reg_ack             = ack_q;
  assign phy_reset_out       = phy_rst_q;
  assign phy_loopback_select = phy_lpbk_q;
  assign phy_speed_100       = phy_spd_q;
  assign phy_full_duplex     = phy_dpx_q;
  assign phy_an_enable       = phy_autoneg_enable_q;
  assign phy_an_restart      = phy_autoneg_restart_q;
  assign phy_power_down      = phy_pd_q;
  assign phy_collision_test  = phy_colt_q;

endmodule // pcr_top

// ===== sim/pcr_monitor.sv
// checker for the phy control and status word pair
module pcr_monitor (
  // clock and reset
  input logic        clk,
  input logic        arst_n,
  // register access
  input logic [7:0]  reg_addr,
  input logic        reg_wr,
  input logic        reg_rd,
  input logic [31:0] reg_wdata,
  input logic [31:0] reg_rdata,
  input logic        reg_ack,
  // transceiver controls
  input logic        phy_reset_out,
  input logic        phy_loopback_select,
  input logic        phy_power_down,
  input logic        phy_an_restart,
  input logic        phy_collision_test
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  // every access is answered one cycle later
  AST_ACK: assert property ((reg_wr || reg_rd) |=> reg_ack)
    else $error("access not acknowledged");
  AST_UPPER: assert property (reg_ack |-> reg_rdata[31:16] == 16'h0000)
    else $error("upper half of read data not zero");
  // fixed ability bits 14..11 and 3, and reserved status and control bits
  AST_FIXED: assert property ((reg_rd && reg_addr == 8'hb8) |=>
    reg_rdata[15:6] == 10'h1e0 && reg_rdata[3])
    else $error("status ability bits wrong");
  AST_CRSVD: assert property ((reg_rd && reg_addr == 8'hb4) |=>
    reg_rdata[10] == 1'b0 && reg_rdata[6:0] == 7'h00)
    else $error("reserved control bits not zero");
  // reset pulse has a length, and it ends on its own
  AST_RST_LEN: assert property ($rose(phy_reset_out) |->
    phy_reset_out [*8])
    else $error("phy reset pulse too short");
  AST_RST_END: assert property (phy_reset_out |-> ##[1:40] !phy_reset_out)
    else $error("phy reset never released");
  // restart pulse comes from a restart write, one cycle long
  AST_AUTONEG_RESTART: assert property ($rose(phy_an_restart) |->
    $past(reg_wr, 2) && $past(reg_wdata[9], 2) &&
    $past(reg_addr, 2) == 8'hb4 ##1 !phy_an_restart)
    else $error("restart pulse without cause or too long");
  // control levels follow the written bits
  AST_PD: assert property ((reg_wr && reg_addr == 8'hb4 &&
    reg_wdata[11] && !reg_wdata[15]) |-> ##[1:3] phy_power_down)
    else $error("power down not applied");
  AST_LPBK: assert property ((reg_wr && reg_addr == 8'hb4 &&
    reg_wdata[14] && !reg_wdata[15]) |-> ##[1:3] phy_loopback_select)
    else $error("loopback not applied");
  AST_COLT: assert property ((reg_wr && reg_addr == 8'hb4 &&
    reg_wdata[7]) |-> ##[1:3] phy_collision_test)
    else $error("collision test not applied");
endmodule // pcr_monitor

bind pcr_top pcr_monitor mon_u (
  .clk, .arst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
  .reg_ack, .phy_reset_out, .phy_loopback_select, .phy_power_down,
  .phy_an_restart, .phy_collision_test
);

// ===== sim/tb.sv
// self-checking bench for the phy control and status word pair
`include "pcr_regs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0;
  logic        arst_n = 0;
  logic [7:0]  reg_addr = '0;
  logic        reg_wr = 0;
  logic        reg_rd = 0;
  logic [31:0] reg_wdata = '0;
  wire  [31:0] reg_rdata;
  wire         reg_ack;
  logic        phy_link_up = 0;
  logic        phy_remote_fault = 0;
  logic        phy_jabber = 0;
  logic        phy_an_done = 0;
  logic        phy_an_speed_100 = 1;
  logic        phy_an_full_duplex = 1;
  wire         phy_reset_out, phy_loopback_select, phy_speed_100;
  wire         phy_full_duplex, phy_an_enable, phy_an_restart;
  wire         phy_power_down, phy_collision_test;
  int          bad_count = 0;
  int          n_tests = 0;
  int          rst_hi = 0;
  int          autoneg_restart_hi = 0;

  pcr_top dut_u (
    .clk, .arst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .reg_ack, .phy_link_up, .phy_remote_fault, .phy_jabber, .phy_an_done,
    .phy_an_speed_100, .phy_an_full_duplex, .phy_reset_out,
    .phy_loopback_select, .phy_speed_100, .phy_full_duplex,
    .phy_an_enable, .phy_an_restart, .phy_power_down, .phy_collision_test
  );

  // 100 ns clock
  always #50 clk = ~clk;

  // pulse widths counted here at every rising edge so a one-cycle pulse is not missed
  always @(posedge clk) begin
    rst_hi += phy_reset_out;
    autoneg_restart_hi += phy_an_restart;
  end

  task summarize;
    $display("checks=%0d mismatches=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one strobe cycle, ack checked, ends on a falling edge so checks settle
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clk);
    reg_wr <= 0;
    reg_rd <= 0;
    #1 chk(reg_ack, 1);
    repeat (3) @(negedge clk);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    acc(1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    acc(0, a, 0);
    chk(reg_rdata & m, e & m);
  endtask

  initial begin
    cyc(8);
    arst_n <= 1;
    rd(8'hb4, 32'h3000, '1);
    rd(8'hb8, 32'h7809, '1);
    chk(phy_speed_100, 1);
    chk(phy_an_enable, 1);
    wr(8'hb8, 32'hffff_ffff);
    rd(8'hb8, 32'h7809, '1);
    // link comes up: still reads failed once, then valid
    @(posedge clk);
    phy_link_up <= 1;
    cyc(5);
    rd(8'hb8, 0, 4);
    rd(8'hb8, 4, 4);
    @(posedge clk);
    phy_link_up <= 0;
    cyc(5);
    phy_link_up <= 1;
    cyc(5);
    rd(8'hb8, 0, 4);
    rd(8'hb8, 4, 4);
    // short remote fault is held until read
    @(posedge clk);
    phy_remote_fault <= 1;
    cyc(4);
    phy_remote_fault <= 0;
    cyc(4);
    rd(8'hb8, 32'h10, 32'h10);
    rd(8'hb8, 0, 32'h10);
    // jabber at 100 is not latched
    @(posedge clk);
    phy_jabber <= 1;
    cyc(4);
    phy_jabber <= 0;
    cyc(4);
    rd(8'hb8, 0, 2);
    // negotiated result wins over forced bits only while negotiation is enabled
    @(posedge clk);
    phy_an_speed_100 <= 0;
    phy_an_full_duplex <= 0;
    wr(8'hb4, 32'h3100);
    chk(phy_speed_100, 0);
    chk(phy_full_duplex, 0);
    wr(8'hb4, 32'h2100);
    chk(phy_speed_100, 1);
    chk(phy_full_duplex, 1);
    rd(8'hb4, 32'h2100, '1);
    wr(8'hb4, 32'h0000);
    chk(phy_speed_100, 0);
    chk(phy_full_duplex, 0);
    // jabber at 10 latches until read
    @(posedge clk);
    phy_jabber <= 1;
    cyc(4);
    phy_jabber <= 0;
    cyc(4);
    rd(8'hb8, 2, 2);
    rd(8'hb8, 0, 2);
    // reserved bits and upper half ignored
    wr(8'hb4, 32'hffff_5cff);
    rd(8'hb4, 32'h5880, '1);
    chk(phy_loopback_select, 1);
    chk(phy_power_down, 1);
    chk(phy_collision_test, 1);
    @(posedge clk);
    phy_an_done <= 1;
    wr(8'hb4, 32'h1000);
    chk(phy_power_down, 0);
    cyc(4);
    rd(8'hb8, 32'h20, 32'h20);
    // restart gives one pulse and clears itself
    autoneg_restart_hi = 0;
    wr(8'hb4, 32'h1200);
    chk(autoneg_restart_hi, `PCR_AUTONEG_RESTART_CYC);
    rd(8'hb4, 32'h1000, '1);
    // soft reset runs its length and clears itself
    rst_hi = 0;
    wr(8'hb4, 32'h9000);
    rd(8'hb4, 32'h8000, 32'h8000);
    cyc(30);
    chk(rst_hi, `PCR_PHY_SOFT_RESET_CYC);
    rd(8'hb4, 32'h1000, '1);
    rd(8'hc0, 0, '1);
    summarize;
  end

  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #1_000_000;
    bad_count++;
    summarize;
  end
endmodule // tb
